// ==== logic/trc_top.sv ====
/*
 * Repeat downcounter, update generation and two compare channels.
 * Assumes the counter, its over/underflow pulses and capture pulses
 * come from timer logic on clk_sys, so none of them is synchronised.
 */
`timescale 1ns/1ps
`include "trc_defines.svh"

module trc_top
    import trc_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    input trc_bus_req_type bus_req, // Register access
    output logic [31:0] rd_data, // Read data, cycle after
    input wire logic [15:0] counter_value, // Timer counter
    input wire logic counter_overflow, // Counter hit top
    input wire logic counter_underflow, // Counter hit bottom
    input wire logic chan1_capture_event, // Channel 1 capture
    input wire logic chan2_capture_event, // Channel 2 capture
    output logic chan1_compare_output, // Channel 1 compare
    output logic chan2_compare_output, // Channel 2 compare
    output logic update_event // Update pulse
);
    // ============================================================
    // Address decode used by every write and the read mux
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
        addr_hit = (addr == offset);
    endfunction

    // ============================================================
    // Declarations
    logic [7:0] repeat_count_value;
    logic [7:0] repeat_downcounter;
    trc_chan_cfg_type chan1_cfg;
    trc_chan_cfg_type chan2_cfg;
    logic period_tick;
    logic force_update;
    logic update_now;
    logic wr_repeat;
    logic wr_chan1;
    logic wr_chan2;
    logic wr_control;
    logic [15:0] chan1_read;
    logic [15:0] chan2_read;
    logic [31:0] next_rd_data;

    // ============================================================
    // Write decode
    assign wr_repeat = bus_req.wr && addr_hit(bus_req.addr, `TRC_REPEAT_OFFSET);
    assign wr_chan1 = bus_req.wr && addr_hit(bus_req.addr, `TRC_CHAN1_OFFSET);
    assign wr_chan2 = bus_req.wr && addr_hit(bus_req.addr, `TRC_CHAN2_OFFSET);
    assign wr_control = bus_req.wr && addr_hit(bus_req.addr, `TRC_CONTROL_OFFSET);

    // ============================================================
    // Repeat count value register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            repeat_count_value <= `TRC_REPEAT_RESET;
        else if (wr_repeat)
            repeat_count_value <= bus_req.wdata[7:0];
    end

    // ============================================================
    // Control register: preload enables and channel modes
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            chan1_cfg <= '0;
            chan2_cfg <= '0;
        end
        else if (wr_control)
        begin
            chan1_cfg.preload_en <= bus_req.wdata[`TRC_CTRL_PRE1_BIT];
            chan2_cfg.preload_en <= bus_req.wdata[`TRC_CTRL_PRE2_BIT];
            chan1_cfg.input_mode <= bus_req.wdata[`TRC_CTRL_IN1_BIT];
            chan2_cfg.input_mode <= bus_req.wdata[`TRC_CTRL_IN2_BIT];
        end
    end

    // Force bit is a write-one pulse; it never stores, so it reads zero
    assign force_update = wr_control && bus_req.wdata[`TRC_CTRL_FORCE_BIT];

    // ============================================================
    // Period tick
    // Edge-aligned counting gives one of the two pulses per full period;
    // center-aligned gives both, one per half period, so the same sum
    // counts whole periods in one case and half periods in the other.
    assign period_tick = counter_overflow || counter_underflow;

    // Update fires when the downcounter is spent, or when forced
    assign update_now = (period_tick && repeat_downcounter == 8'h00) || force_update;

    // ============================================================
    // Repeat downcounter
    // Reload only at update, so a new value waits for the end of the current repeat cycle.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            repeat_downcounter <= `TRC_REPEAT_RESET;
        else if (update_now)
            repeat_downcounter <= repeat_count_value;
        else if (period_tick)
            repeat_downcounter <= repeat_downcounter - 8'h01;
    end

    // Registered update pulse for the rest of the timer
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            update_event <= 1'b0;
        else
            update_event <= update_now;
    end

    // ============================================================
    // Channels; compare writes use only bits 15:0, upper bits ignored
    trc_channel u_channel_one (
        .clk_sys(clk_sys),
        .rst(rst),
        .cfg(chan1_cfg),
        .write_strobe(wr_chan1),
        .write_value(bus_req.wdata[15:0]),
        .update_now(update_now),
        .capture_event(chan1_capture_event),
        .counter_value(counter_value),
        .read_value(chan1_read),
        .compare_output(chan1_compare_output)
    );

    trc_channel u_channel_two (
        .clk_sys(clk_sys),
        .rst(rst),
        .cfg(chan2_cfg),
        .write_strobe(wr_chan2),
        .write_value(bus_req.wdata[15:0]),
        .update_now(update_now),
        .capture_event(chan2_capture_event),
        .counter_value(counter_value),
        .read_value(chan2_read),
        .compare_output(chan2_compare_output)
    );

    // ============================================================
    // Read mux; unmapped addresses and reserved bits read zero
    always_comb
    begin
        next_rd_data = `TRC_READ_ZERO;
        if (addr_hit(bus_req.addr, `TRC_REPEAT_OFFSET))
            next_rd_data[7:0] = repeat_count_value;
        else if (addr_hit(bus_req.addr, `TRC_CHAN1_OFFSET))
            next_rd_data[15:0] = chan1_read;
        else if (addr_hit(bus_req.addr, `TRC_CHAN2_OFFSET))
            next_rd_data[15:0] = chan2_read;
        else if (addr_hit(bus_req.addr, `TRC_CONTROL_OFFSET))
        begin
            next_rd_data[`TRC_CTRL_PRE1_BIT] = chan1_cfg.preload_en;
            next_rd_data[`TRC_CTRL_PRE2_BIT] = chan2_cfg.preload_en;
            next_rd_data[`TRC_CTRL_IN1_BIT] = chan1_cfg.input_mode;
            next_rd_data[`TRC_CTRL_IN2_BIT] = chan2_cfg.input_mode;
        end
        else if (addr_hit(bus_req.addr, `TRC_STATUS_OFFSET))
        begin
            next_rd_data[7:0] = repeat_downcounter;
            next_rd_data[`TRC_STAT_OUT1_BIT] = chan1_compare_output;
            next_rd_data[`TRC_STAT_OUT2_BIT] = chan2_compare_output;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rd_data <= `TRC_READ_ZERO;
        else if (bus_req.rd)
            rd_data <= next_rd_data;
        else
            rd_data <= `TRC_READ_ZERO;
    end

    // ============================================================
    // Helper logic for the checks: ticks since the last update and
    // the value the downcounter was last loaded with.
    // The counts start only after a first update, since reset leaves
    // the downcounter at zero rather than at a loaded value.
    logic [8:0] chk_ticks;
    logic [7:0] chk_loaded;
    logic chk_armed;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            chk_ticks <= 9'h000;
            chk_loaded <= 8'h00;
            chk_armed <= 1'b0;
        end
        else if (update_now)
        begin
            chk_ticks <= 9'h000;
            chk_loaded <= repeat_count_value;
            chk_armed <= 1'b1;
        end
        else if (period_tick)
            chk_ticks <= chk_ticks + 9'h001;
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_repeat_write;
        wr_repeat;
    endsequence

    sequence s_repeat_read;
        bus_req.rd && addr_hit(bus_req.addr, `TRC_REPEAT_OFFSET);
    endsequence

    sequence s_spent_tick;
        period_tick && repeat_downcounter == 8'h00;
    endsequence

    a_repeat_store: assert property (s_repeat_write ##1 s_repeat_read
        |=> rd_data == {24'h00_0000, $past(bus_req.wdata[7:0], 2)})
        else $error("repeat value not stored or read back");

    a_read_once: assert property (!bus_req.rd |=> rd_data == `TRC_READ_ZERO)
        else $error("read data stood without a read");

    a_update_on_zero: assert property (s_spent_tick
        |=> update_event && repeat_downcounter == $past(repeat_count_value))
        else $error("no update at zero");

    a_no_early_update: assert property (period_tick && repeat_downcounter != 8'h00 && !force_update
        |=> !update_event && repeat_downcounter == $past(repeat_downcounter) - 8'h01)
        else $error("downcounter step wrong");

    a_reload_only_update: assert property (!update_now && !period_tick |=> $stable(repeat_downcounter))
        else $error("downcounter moved without tick");

    a_period_count: assert property ((chk_armed && !force_update) and s_spent_tick
        |-> chk_ticks + 9'h001 == {1'b0, chk_loaded} + 9'h001)
        else $error("update spacing not repeat plus one");

    a_force_reload: assert property (force_update
        |=> update_event && repeat_downcounter == $past(repeat_count_value))
        else $error("forced update did not reload");

    // Delayed copies for the transfer check below
    logic [15:0] counter_value_d1;
    logic [15:0] chan1_read_d1;
    logic [15:0] chan1_read_d2;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            counter_value_d1 <= `TRC_COMPARE_RESET;
            chan1_read_d1 <= `TRC_COMPARE_RESET;
            chan1_read_d2 <= `TRC_COMPARE_RESET;
        end
        else
        begin
            counter_value_d1 <= counter_value;
            chan1_read_d1 <= chan1_read;
            chan1_read_d2 <= chan1_read_d1;
        end
    end

    a_preload_move: assert property (update_now && chan1_cfg.preload_en && !chan1_cfg.input_mode && !wr_chan1
        ##1 chan1_cfg.preload_en && !chan1_cfg.input_mode
        ##1 chan1_cfg.preload_en && !chan1_cfg.input_mode
        |-> chan1_compare_output == (counter_value_d1 < chan1_read_d2))
        else $error("preload not moved at update");

    a_reserved_zero: assert property (bus_req.rd && !addr_hit(bus_req.addr, `TRC_STATUS_OFFSET)
        |=> rd_data[31:16] == 16'h0000)
        else $error("reserved bits not zero");
endmodule

// ==== common/trc_defines.svh ====
/*
 * Offsets, field positions and reset values of the repeat and compare block.
 * Assumes it is included by its bare name from the three modules.
 */
// ============================================================
`ifndef TRC_DEFINES_SVH
`define TRC_DEFINES_SVH

// ============================================================
// Register byte addresses
`define TRC_REPEAT_OFFSET 8'h30
`define TRC_CHAN1_OFFSET 8'h34
`define TRC_CHAN2_OFFSET 8'h38
`define TRC_CONTROL_OFFSET 8'h60
`define TRC_STATUS_OFFSET 8'h64

// ============================================================
// Reset values
`define TRC_REPEAT_RESET 8'h00
`define TRC_COMPARE_RESET 16'h0000
`define TRC_READ_ZERO 32'h0000_0000

// ============================================================
// Control register fields
`define TRC_CTRL_PRE1_BIT 0
`define TRC_CTRL_PRE2_BIT 1
`define TRC_CTRL_IN1_BIT 2
`define TRC_CTRL_IN2_BIT 3
`define TRC_CTRL_FORCE_BIT 4

// ============================================================
// Status register fields
`define TRC_STAT_OUT1_BIT 8
`define TRC_STAT_OUT2_BIT 9

`endif

// ==== common/trc_pkg.sv ====
/*
 * Types shared by the repeat and compare block.
 * Assumes the defines header sits on the include path.
 */
// ============================================================
// Package
package trc_pkg;
    // Register port request, one cycle per access
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } trc_bus_req_type;

    // Per-channel configuration
    typedef struct packed {
        logic preload_en;
        logic input_mode;
    } trc_chan_cfg_type;
endpackage

// ==== logic/trc_channel.sv ====
/*
 * One capture/compare channel: preload, active value, capture and compare.
 * Assumes write strobes and events are one-cycle pulses on clk_sys.
 */
`timescale 1ns/1ps
`include "trc_defines.svh"

module trc_channel
    import trc_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    input trc_chan_cfg_type cfg, // Preload and mode
    input wire logic write_strobe, // Register write pulse
    input wire logic [15:0] write_value, // Written compare value
    input wire logic update_now, // Update event pulse
    input wire logic capture_event, // Capture pulse
    input wire logic [15:0] counter_value, // Timer counter
    output logic [15:0] read_value, // Value seen by software
    output logic compare_output // Compare result
);
    logic [15:0] preload;
    logic [15:0] active;

    // ============================================================
    // Preload holds the last software value in output mode
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            preload <= `TRC_COMPARE_RESET;
        else if (write_strobe && !cfg.input_mode)
            preload <= write_value;
    end

    // Active value: capture, direct write, or transfer at update
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            active <= `TRC_COMPARE_RESET;
        else if (cfg.input_mode)
        begin
            if (capture_event)
                active <= counter_value;
        end
        else if (write_strobe && !cfg.preload_en)
            active <= write_value;
        else if (update_now && cfg.preload_en)
            active <= preload;
    end

    // Output high while the counter is below the active value, held low in input mode
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            compare_output <= 1'b0;
        else
            compare_output <= !cfg.input_mode && (counter_value < active);
    end

    // Software sees the capture in input mode, the preload otherwise
    assign read_value = cfg.input_mode ? active : preload;

    // ============================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_direct_write: assert property (write_strobe && !cfg.input_mode && !cfg.preload_en
        |=> active == $past(write_value))
        else $error("direct write missed active value");
    a_preload_hold: assert property (write_strobe && cfg.preload_en && !cfg.input_mode && !update_now
        ##1 (!update_now && !write_strobe && cfg.preload_en && !cfg.input_mode)
        |=> active == $past(active, 1))
        else $error("preload leaked before update");
    a_compare_drive: assert property (!cfg.input_mode ##1 !cfg.input_mode
        |-> compare_output == ($past(counter_value) < $past(active)))
        else $error("compare output wrong");
    a_capture_latch: assert property (cfg.input_mode && capture_event
        |=> active == $past(counter_value) && read_value == active)
        else $error("capture not latched");
endmodule

// ==== bench/tb.sv ====
/*
 * Self-checking testbench for the repeat and compare block top.
 * Assumes the defines header is on the include path and the package is compiled first.
 */
`timescale 1ns/1ps
`include "trc_defines.svh"

module tb
    import trc_pkg::*;
;
    // ============================================================
    // Signals
    logic clk_sys;
    logic rst;
    trc_bus_req_type bus_req;
    logic [31:0] rd_data;
    logic [15:0] counter_value;
    logic counter_overflow;
    logic counter_underflow;
    logic chan1_capture_event;
    logic chan2_capture_event;
    logic chan1_compare_output;
    logic chan2_compare_output;
    logic update_event;
    logic [31:0] rd_val;
    int error_cnt;
    int checks;

    trc_top uut (
        .clk_sys(clk_sys),
        .rst(rst),
        .bus_req(bus_req),
        .rd_data(rd_data),
        .counter_value(counter_value),
        .counter_overflow(counter_overflow),
        .counter_underflow(counter_underflow),
        .chan1_capture_event(chan1_capture_event),
        .chan2_capture_event(chan2_capture_event),
        .chan1_compare_output(chan1_compare_output),
        .chan2_compare_output(chan2_compare_output),
        .update_event(update_event)
    );

    // ============================================================
    // Clock, 40 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ============================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe beside address and data
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk_sys);
        bus_req.addr <= addr;
        bus_req.wdata <= data;
        bus_req.wr <= 1'b1;
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] addr);
        @(posedge clk_sys);
        bus_req.addr <= addr;
        bus_req.rd <= 1'b1;
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1;
        rd_val = rd_data;
    endtask

    // Write then read with the strobes back to back, no idle cycle between
    task automatic wr_rd(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk_sys);
        bus_req.addr <= addr;
        bus_req.wdata <= data;
        bus_req.wr <= 1'b1;
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b1;
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1;
        rd_val = rd_data;
    endtask

    // One period tick; update pulse shows in the cycle after the tick is taken
    task automatic tick(input logic under, input logic exp);
        @(posedge clk_sys);
        counter_overflow <= ~under;
        counter_underflow <= under;
        @(posedge clk_sys);
        counter_overflow <= 1'b0;
        counter_underflow <= 1'b0;
        #1;
        check({31'h0, update_event}, {31'h0, exp});
    endtask

    // A run of n ticks that must update only on the last; alt mixes both tick kinds
    task automatic run(input int n, input logic alt);
        for (int i = 0; i < n; i++)
        begin
            tick(alt & i[0], i == n - 1);
        end
    endtask

    // Compare outputs are registered on a registered active value, so allow three edges
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic outs(input logic o1, input logic o2);
        check({30'h0, chan2_compare_output, chan1_compare_output}, {30'h0, o2, o1});
    endtask

    task automatic cap(input logic second);
        @(posedge clk_sys);
        chan1_capture_event <= ~second;
        chan2_capture_event <= second;
        @(posedge clk_sys);
        chan1_capture_event <= 1'b0;
        chan2_capture_event <= 1'b0;
    endtask

    task automatic stop_test();
        if (error_cnt == 0 && checks > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ============================================================
    // Watchdog; the whole run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        stop_test();
    end

    // ============================================================
    // Main sequence
    initial
    begin
        error_cnt = 0;
        checks = 0;
        rst = 1'b1;
        bus_req = '0;
        counter_value = 16'h0000;
        counter_overflow = 1'b0;
        counter_underflow = 1'b0;
        chan1_capture_event = 1'b0;
        chan2_capture_event = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values and field width
        rd(`TRC_REPEAT_OFFSET); check(rd_val, 32'h0000_0000);
        rd(`TRC_CHAN1_OFFSET); check(rd_val, 32'h0000_0000);
        rd(`TRC_CHAN2_OFFSET); check(rd_val, 32'h0000_0000);
        wr_rd(`TRC_REPEAT_OFFSET, 32'hFFFF_FF02); check(rd_val, 32'h0000_0002);
        // Unmapped place ignores writes and reads zero
        wr(8'h50, 32'hFFFF_FFFF);
        rd(8'h50); check(rd_val, 32'h0000_0000);
        // Downcounter starts at zero, so the first tick updates and loads 2
        tick(1'b0, 1'b1);
        rd(`TRC_STATUS_OFFSET); check(rd_val, 32'h0000_0002);
        run(3, 1'b0);
        // A new value waits for the next update
        wr(`TRC_REPEAT_OFFSET, 32'h0000_0001);
        run(3, 1'b0);
        run(2, 1'b0);
        // Centre-aligned: both tick kinds count as half periods
        run(2, 1'b1);
        run(2, 1'b1);
        // Channel 1 straight through, compare boundary
        @(posedge clk_sys) counter_value <= 16'h0800;
        wr(`TRC_CHAN1_OFFSET, 32'h0000_1000);
        settle(); outs(1'b1, 1'b0);
        @(posedge clk_sys) counter_value <= 16'h1000;
        settle(); outs(1'b0, 1'b0);
        @(posedge clk_sys) counter_value <= 16'h0FFF;
        settle(); outs(1'b1, 1'b0);
        // Channel 1 preload holds until a forced update
        wr(`TRC_CONTROL_OFFSET, 32'h0000_0001);
        wr(`TRC_CHAN1_OFFSET, 32'h0000_0200);
        settle(); outs(1'b1, 1'b0);
        rd(`TRC_CHAN1_OFFSET); check(rd_val, 32'h0000_0200);
        tick(1'b0, 1'b0);
        wr(`TRC_CONTROL_OFFSET, 32'h0000_0011);
        settle(); outs(1'b0, 1'b0);
        rd(`TRC_STATUS_OFFSET); check(rd_val, 32'h0000_0001);
        // Channel 2 preload moves only at the repeat update
        wr(`TRC_CONTROL_OFFSET, 32'h0000_0003);
        wr(`TRC_CHAN2_OFFSET, 32'h0000_2000);
        settle(); outs(1'b0, 1'b0);
        tick(1'b0, 1'b0);
        settle(); outs(1'b0, 1'b0);
        tick(1'b1, 1'b1);
        settle(); outs(1'b0, 1'b1);
        rd(`TRC_STATUS_OFFSET); check(rd_val, 32'h0000_0201);
        // Channel 2 straight through
        wr(`TRC_CONTROL_OFFSET, 32'h0000_0001);
        wr(`TRC_CHAN2_OFFSET, 32'h0000_0100);
        settle(); outs(1'b0, 1'b0);
        // Input mode: captures latch the counter, writes are ignored
        wr(`TRC_CONTROL_OFFSET, 32'h0000_000C);
        settle(); outs(1'b0, 1'b0);
        @(posedge clk_sys) counter_value <= 16'h1234;
        cap(1'b0);
        rd(`TRC_CHAN1_OFFSET); check(rd_val, 32'h0000_1234);
        @(posedge clk_sys) counter_value <= 16'hBEEF;
        cap(1'b1);
        rd(`TRC_CHAN2_OFFSET); check(rd_val, 32'h0000_BEEF);
        rd(`TRC_CHAN1_OFFSET); check(rd_val, 32'h0000_1234);
        wr(`TRC_CHAN1_OFFSET, 32'h0000_5555);
        rd(`TRC_CHAN1_OFFSET); check(rd_val, 32'h0000_1234);
        cap(1'b0);
        rd(`TRC_CHAN1_OFFSET); check(rd_val, 32'h0000_BEEF);
        stop_test();
    end
endmodule
